// >>> common/mpi_defines.vh
// constants for the memory programming interface
// assumes a 125 MHz system clock; included by rtl/mpi_top.v
`ifndef MPI_DEFINES_VH
`define MPI_DEFINES_VH
`define MPI_CLK_MHZ      125
`define MPI_T_FLASH_US   4500
`define MPI_T_EEPROM_US  4000
`define MPI_T_ERASE_US   4000
`define MPI_T_FUSE_US    4500
`define MPI_CYC(us)      ((us) * `MPI_CLK_MHZ)
// parallel action codes
`define MPI_ACT_ADDR     2'h0
`define MPI_ACT_DATA     2'h1
`define MPI_ACT_CMD      2'h2
// parallel commands
`define MPI_CMD_ERASE    8'h80
`define MPI_CMD_WFUSE    8'h40
`define MPI_CMD_WLOCK    8'h20
`define MPI_CMD_WFLASH   8'h10
`define MPI_CMD_WEEP     8'h11
`define MPI_CMD_RSIG     8'h08
`define MPI_CMD_RFUSE    8'h04
`define MPI_CMD_RFLASH   8'h02
`define MPI_CMD_REEP     8'h03
// serial first bytes and second bytes
`define MPI_S_PGEN       8'hAC
`define MPI_S_ENB2       8'h53
`define MPI_S_ERB2       8'h80
`define MPI_S_WLB2       8'hE0
`define MPI_S_WFLB2      8'hA0
`define MPI_S_WFHB2      8'hA8
`define MPI_S_WFEB2      8'hA4
`define MPI_S_POLL       8'hF0
`define MPI_S_LDFL       8'h40
`define MPI_S_LDFH       8'h48
`define MPI_S_WFPG       8'h4C
`define MPI_S_LDEP       8'hC1
`define MPI_S_WEPG       8'hC2
`define MPI_S_WEB        8'hC0
`define MPI_S_RFL        8'h20
`define MPI_S_RFH        8'h28
`define MPI_S_REEP       8'hA0
`define MPI_S_RLOCK      8'h58
`define MPI_S_RFUSE      8'h50
`define MPI_S_RSIG       8'h30
`define MPI_S_RCAL       8'h38
// reset values and field masks
`define MPI_FUSE_LO_RST  8'hFF
`define MPI_FUSE_HI_RST  8'hFF
`define MPI_FUSE_EX_RST  8'hFF
`define MPI_LOCK_RST     8'hFF
`define MPI_BOOT_MASK    8'h3C
`define MPI_ERASED       8'hFF
`endif

// >>> rtl/mpi_top.v
// nonvolatile memory programming port: parallel pins and serial link
// assumes all pins asynchronous to clk_sys_i; par_mode_i comes from local logic
`include "mpi_defines.vh"
module mpi_top #(
    parameter [19:0] FLASH_WAIT  = `MPI_CYC(`MPI_T_FLASH_US),
    parameter [19:0] EEPROM_WAIT = `MPI_CYC(`MPI_T_EEPROM_US),
    parameter [19:0] ERASE_WAIT  = `MPI_CYC(`MPI_T_ERASE_US),
    parameter [19:0] FUSE_WAIT   = `MPI_CYC(`MPI_T_FUSE_US),
    // identification and calibration values are arbitrary
    parameter [7:0]  SIG0        = 8'h5A,
    parameter [7:0]  SIG1        = 8'hA5,
    parameter [7:0]  SIG2        = 8'h3C,
    parameter [7:0]  CAL_BYTE    = 8'h80
)(
    // clock, reset, enable, port mode
    input  wire       clk_sys_i,
    input  wire       rst_i,
    input  wire       ce_i,
    input  wire       par_mode_i,
    // parallel pins
    input  wire       clock_input_pin_i,
    input  wire       action_select_0_i,
    input  wire       action_select_1_i,
    input  wire       byte_select_1_i,
    input  wire       write_strobe_n_i,
    input  wire       output_enable_n_i,
    input  wire [7:0] data_i,
    output reg  [7:0] data_o,
    output reg        data_oe_o,
    output reg        ready_busy_o,
    // serial pins
    input  wire       reset_pin_n_i,
    input  wire       sck_i,
    input  wire       mosi_i,
    output reg        miso_o
);
////////////////////////////////////////////////////////////////////////////////
localparam NS      = 17;
localparam PIN_RST = 17'h00070;
localparam K_NONE  = 3'h0;
localparam K_ERASE = 3'h1;
localparam K_FPAGE = 3'h2;
localparam K_EPAGE = 3'h3;
localparam K_EBYTE = 3'h4;
localparam K_FUSE  = 3'h5;
localparam K_LOCK  = 3'h6;
localparam W_IDLE  = 2'h0;
localparam W_ERASE = 2'h1;
localparam W_FPAGE = 2'h2;
localparam W_EPAGE = 2'h3;

reg  [NS-1:0] s1_r, s2_r, s3_r, pin_r;
wire [NS-1:0] pin_nxt = ((s2_r ~^ s3_r) & s3_r) | ((s2_r ^ s3_r) & pin_r);
wire [NS-1:0] rise    = pin_nxt & ~pin_r;
wire [NS-1:0] fall    = ~pin_nxt & pin_r;
wire [7:0]    pd      = pin_nxt[16:9];
wire          bs1     = pin_nxt[3];
wire          bs2     = pin_nxt[2];

reg  [15:0]   flash [0:2047];
reg  [7:0]    eep   [0:63];
reg  [15:0]   fbuf  [0:31];
reg  [7:0]    ebuf  [0:3];
reg  [3:0]    emask_r;
reg  [7:0]    cmd_r, ahi_r, alo_r, fuse_dat_r;
reg  [7:0]    fuse_lo_r, fuse_hi_r, fuse_ex_r, lock_r;
reg  [19:0]   tmr_r;
reg  [1:0]    wk_r;
reg  [10:0]   ptr_r;
reg  [5:0]    page_r;
reg  [31:0]   sreg_r;
reg  [4:0]    bcnt_r;
reg           pe_r;
reg  [7:0]    txv_r, tx_r;
reg           tx_ld_r;

wire        busy    = (tmr_r != 20'h00000) || (wk_r != W_IDLE);
wire        ser_act = !par_mode_i && !pin_r[6];
wire        p_clk   = par_mode_i && rise[0];
wire        p_wr    = par_mode_i && fall[4];
wire        s_rise  = ser_act && rise[7];
wire [31:0] ins     = {sreg_r[30:0], pin_nxt[8]};
wire        s_exec  = s_rise && (bcnt_r == 5'h1F);
wire [10:0] pfa     = {ahi_r[2:0], alo_r};
wire [10:0] sfa     = {ins[10:8], ins[7:0]};
wire        mode3   = (lock_r[1:0] == 2'h0);
////////////////////////////////////////////////////////////////////////////////
// operation decode from either port
reg  [2:0]  op_k;
reg  [1:0]  op_sel;
reg  [5:0]  op_a;
reg  [7:0]  op_d;
always @* begin
    op_k   = K_NONE;
    op_sel = 2'h0;
    op_a   = 6'h00;
    op_d   = pd;
    if (p_wr) begin
        case (cmd_r)
            `MPI_CMD_ERASE:  op_k = K_ERASE;
            `MPI_CMD_WFLASH: begin
                op_k = K_FPAGE;
                op_a = {ahi_r[2:0], alo_r[7:5]};
            end
            `MPI_CMD_WEEP: begin
                op_k = bs1 ? K_NONE : K_EPAGE;
                op_a = {2'h0, alo_r[5:2]};
            end
            `MPI_CMD_WFUSE: begin
                op_k   = K_FUSE;
                op_sel = {bs2, bs1};
                op_d   = fuse_dat_r;
            end
            `MPI_CMD_WLOCK: begin
                op_k = K_LOCK;
                op_d = fuse_dat_r;
            end
            default: op_k = K_NONE;
        endcase
    end else if (s_exec && pe_r) begin
        op_d = ins[7:0];
        case (ins[31:24])
            `MPI_S_PGEN: begin
                case (ins[23:16])
                    `MPI_S_ERB2:  op_k = K_ERASE;
                    `MPI_S_WLB2:  op_k = K_LOCK;
                    `MPI_S_WFLB2: op_k = K_FUSE;
                    `MPI_S_WFHB2: begin
                        op_k   = K_FUSE;
                        op_sel = 2'h1;
                    end
                    `MPI_S_WFEB2: begin
                        op_k   = K_FUSE;
                        op_sel = 2'h2;
                    end
                    default: op_k = K_NONE;
                endcase
            end
            `MPI_S_WFPG: begin
                op_k = K_FPAGE;
                op_a = {ins[18:16], ins[15:13]};
            end
            `MPI_S_WEPG: begin
                op_k = K_EPAGE;
                op_a = {2'h0, ins[13:10]};
            end
            `MPI_S_WEB: begin
                op_k = K_EBYTE;
                op_a = ins[13:8];
            end
            default: op_k = K_NONE;
        endcase
    end
end
////////////////////////////////////////////////////////////////////////////////
// serial read byte, chosen once the third byte is in
reg [7:0] s_rd;
always @* begin
    case (ins[23:16])
        `MPI_S_POLL: s_rd = {7'h00, busy};
        // address bytes sit in the low 16 bits once 24 bits are in
        `MPI_S_RFL:  s_rd = flash[sfa][7:0];
        `MPI_S_RFH:  s_rd = flash[sfa][15:8];
        `MPI_S_REEP: s_rd = eep[ins[5:0]];
        `MPI_S_RLOCK: s_rd = ins[11] ? fuse_hi_r : lock_r;
        `MPI_S_RFUSE: s_rd = ins[11] ? fuse_ex_r : fuse_lo_r;
        `MPI_S_RSIG: s_rd = (ins[1:0] == 2'h0) ? SIG0 : (ins[1:0] == 2'h1) ? SIG1 : SIG2;
        `MPI_S_RCAL: s_rd = CAL_BYTE;
        default:     s_rd = 8'h00;
    endcase
end
////////////////////////////////////////////////////////////////////////////////
// parallel read byte
reg [7:0] p_rd;
reg       p_rdv;
always @* begin
    p_rdv = 1'b1;
    case (cmd_r)
        `MPI_CMD_RFLASH: p_rd = pin_r[3] ? flash[pfa][15:8] : flash[pfa][7:0];
        `MPI_CMD_REEP:   p_rd = eep[alo_r[5:0]];
        `MPI_CMD_RFUSE: begin
            case ({pin_r[2], pin_r[3]})
                2'h0:    p_rd = fuse_lo_r;
                2'h3:    p_rd = fuse_hi_r;
                2'h2:    p_rd = fuse_ex_r;
                default: p_rd = lock_r;
            endcase
        end
        `MPI_CMD_RSIG: begin
            if (pin_r[3]) p_rd = CAL_BYTE;
            else if (alo_r[1:0] == 2'h0) p_rd = SIG0;
            else if (alo_r[1:0] == 2'h1) p_rd = SIG1;
            else p_rd = SIG2;
        end
        default: begin
            p_rd  = 8'h00;
            p_rdv = 1'b0;
        end
    endcase
end
////////////////////////////////////////////////////////////////////////////////
always @(posedge clk_sys_i) begin
    if (rst_i) begin
        s1_r <= PIN_RST;
        s2_r <= PIN_RST;
        s3_r <= PIN_RST;
        pin_r <= PIN_RST;
        cmd_r <= 8'h00;
        ahi_r <= 8'h00;
        alo_r <= 8'h00;
        fuse_dat_r <= 8'hFF;
        emask_r <= 4'h0;
        fuse_lo_r <= `MPI_FUSE_LO_RST;
        fuse_hi_r <= `MPI_FUSE_HI_RST;
        fuse_ex_r <= `MPI_FUSE_EX_RST;
        lock_r <= `MPI_LOCK_RST;
        tmr_r <= 20'h00000;
        wk_r <= W_IDLE;
        ptr_r <= 11'h000;
        page_r <= 6'h00;
        sreg_r <= 32'h00000000;
        bcnt_r <= 5'h00;
        pe_r <= 1'b0;
        txv_r <= 8'h00;
        tx_r <= 8'h00;
        tx_ld_r <= 1'b0;
        miso_o <= 1'b0;
        data_o <= 8'h00;
        data_oe_o <= 1'b0;
        ready_busy_o <= 1'b1;
    end else if (ce_i) begin
        s1_r <= {data_i, mosi_i, sck_i, reset_pin_n_i, output_enable_n_i, write_strobe_n_i,
                 byte_select_1_i, action_select_1_i, action_select_0_i, clock_input_pin_i};
        s2_r <= s1_r;
        s3_r <= s2_r;
        pin_r <= pin_nxt;
        ready_busy_o <= !busy;
        data_oe_o <= par_mode_i && !pin_r[5] && p_rdv;
        data_o <= p_rd;
        // parallel loads; command and address stay until reloaded
        if (p_clk) begin
            case (pin_nxt[2:1])
                `MPI_ACT_ADDR: begin
                    if (bs1) ahi_r <= pd;
                    else alo_r <= pd;
                end
                `MPI_ACT_DATA: begin
                    fuse_dat_r <= pd;
                    if (cmd_r == `MPI_CMD_WFLASH) begin
                        if (bs1) fbuf[alo_r[4:0]][15:8] <= pd;
                        else fbuf[alo_r[4:0]][7:0] <= pd;
                    end
                    if (cmd_r == `MPI_CMD_WEEP) begin
                        ebuf[alo_r[1:0]] <= pd;
                        emask_r[alo_r[1:0]] <= 1'b1;
                    end
                end
                `MPI_ACT_CMD: cmd_r <= pd;
                default: cmd_r <= cmd_r;
            endcase
        end
        // serial shifter
        if (!ser_act) begin
            bcnt_r <= 5'h00;
            pe_r <= 1'b0;
            tx_ld_r <= 1'b0;
        end else begin
            if (s_rise) begin
                sreg_r <= ins;
                bcnt_r <= bcnt_r + 5'h01;
                if (bcnt_r[2:0] == 3'h7) begin
                    tx_ld_r <= 1'b1;
                    if (bcnt_r == 5'h0F) txv_r <= ins[7:0];
                    else if (bcnt_r == 5'h17) txv_r <= s_rd;
                    else txv_r <= 8'h00;
                end
                if (s_exec && ins[31:16] == {`MPI_S_PGEN, `MPI_S_ENB2}) pe_r <= 1'b1;
                if (s_exec && pe_r) begin
                    case (ins[31:24])
                        `MPI_S_LDFL: fbuf[ins[12:8]][7:0] <= ins[7:0];
                        `MPI_S_LDFH: fbuf[ins[12:8]][15:8] <= ins[7:0];
                        `MPI_S_LDEP: begin
                            ebuf[ins[9:8]] <= ins[7:0];
                            emask_r[ins[9:8]] <= 1'b1;
                        end
                        default: tx_ld_r <= 1'b1;
                    endcase
                end
            end
            if (fall[7]) begin
                tx_ld_r <= 1'b0;
                miso_o <= tx_ld_r ? txv_r[7] : tx_r[7];
                tx_r <= tx_ld_r ? {txv_r[6:0], 1'b0} : {tx_r[6:0], 1'b0};
            end
        end
        // start of an operation; ignored while busy
        if (tmr_r != 20'h00000) tmr_r <= tmr_r - 20'h00001;
        if (op_k != K_NONE && !busy) begin
            ptr_r <= 11'h000;
            page_r <= op_a;
            case (op_k)
                K_ERASE: begin
                    wk_r <= W_ERASE;
                    tmr_r <= ERASE_WAIT;
                end
                K_FPAGE: begin
                    wk_r <= W_FPAGE;
                    tmr_r <= FLASH_WAIT;
                end
                K_EPAGE: begin
                    wk_r <= W_EPAGE;
                    tmr_r <= EEPROM_WAIT;
                end
                K_EBYTE: begin
                    eep[op_a] <= op_d;
                    tmr_r <= EEPROM_WAIT;
                end
                K_FUSE: begin
                    if (op_sel == 2'h0) fuse_lo_r <= op_d;
                    else if (op_sel == 2'h1) fuse_hi_r <= op_d;
                    else if (op_sel == 2'h2) fuse_ex_r <= op_d;
                    tmr_r <= FUSE_WAIT;
                end
                K_LOCK: begin
                    lock_r <= lock_r & (mode3 ? (op_d | `MPI_BOOT_MASK) : op_d);
                    tmr_r <= FUSE_WAIT;
                end
                default: tmr_r <= tmr_r;
            endcase
        end
        // memory walker
        case (wk_r)
            W_ERASE: begin
                flash[ptr_r] <= {`MPI_ERASED, `MPI_ERASED};
                eep[ptr_r[5:0]] <= `MPI_ERASED;
                ptr_r <= ptr_r + 11'h001;
                if (ptr_r == 11'h7FF) begin
                    lock_r <= `MPI_LOCK_RST;
                    emask_r <= 4'h0;
                    wk_r <= W_IDLE;
                end
            end
            W_FPAGE: begin
                flash[{page_r, ptr_r[4:0]}] <= fbuf[ptr_r[4:0]];
                fbuf[ptr_r[4:0]] <= {`MPI_ERASED, `MPI_ERASED};
                ptr_r <= ptr_r + 11'h001;
                if (ptr_r[4:0] == 5'h1F) wk_r <= W_IDLE;
            end
            W_EPAGE: begin
                if (emask_r[ptr_r[1:0]]) eep[{page_r[3:0], ptr_r[1:0]}] <= ebuf[ptr_r[1:0]];
                ptr_r <= ptr_r + 11'h001;
                if (ptr_r[1:0] == 2'h3) begin
                    emask_r <= 4'h0;
                    wk_r <= W_IDLE;
                end
            end
            W_IDLE: ; // an operation start above picks the next state
            default: wk_r <= W_IDLE;
        endcase
    end
end
endmodule

// >>> verification/mpi_asserts.sv
// checker for the memory programming port, bound to mpi_top
// assumes one clock domain and a synchronous active-high reset
module mpi_asserts #(
    parameter [19:0] FLASH_WAIT  = 20'h003E8,
    parameter [19:0] EEPROM_WAIT = 20'h003E8,
    parameter [19:0] ERASE_WAIT  = 20'h00834,
    parameter [19:0] FUSE_WAIT   = 20'h003E8
)(
    // clock, reset and mode
    input wire       clk_sys_i,
    input wire       rst_i,
    input wire       par_mode_i,
    // pins
    input wire       write_strobe_n_i,
    input wire       output_enable_n_i,
    input wire       sck_i,
    // answers
    input wire       data_oe_o,
    input wire       ready_busy_o,
    input wire       miso_o
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam int BUSY_MAX = FLASH_WAIT + EEPROM_WAIT + ERASE_WAIT + FUSE_WAIT + 64;
    localparam int BUSY_MIN = 36;
    int         busy_cnt;
    logic [3:0] ws_age;
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (rst_i);
    ////////////////////////////////////////////////////////////////
    // busy length and cycles since the last strobe fall
    always_ff @(posedge clk_sys_i) begin
        busy_cnt <= (rst_i || ready_busy_o) ? 0 : busy_cnt + 1;
        if (rst_i || $fell(write_strobe_n_i)) begin
            ws_age <= 4'h0;
        end else if (ws_age != 4'hF) begin
            ws_age <= ws_age + 4'h1;
        end
    end
    ////////////////////////////////////////////////////////////////
    a_reset_idle: assert property (disable iff (1'b0) rst_i |=> ready_busy_o && !data_oe_o && !miso_o)
        else $error("outputs not idle after reset");
    a_oe_release: assert property (output_enable_n_i [*8] |-> !data_oe_o)
        else $error("bus still driven after output enable released");
    a_oe_cause: assert property ($rose(data_oe_o) |-> !output_enable_n_i && !$past(output_enable_n_i, 2))
        else $error("bus driven without output enable");
    a_busy_cause: assert property ($fell(ready_busy_o) && par_mode_i |-> ws_age >= 4'h2 && ws_age <= 4'h8)
        else $error("busy not caused by a write strobe");
    a_busy_min: assert property ($fell(ready_busy_o) |-> !ready_busy_o [*8])
        else $error("busy too short");
    a_busy_floor: assert property ($rose(ready_busy_o) && par_mode_i |-> busy_cnt >= BUSY_MIN)
        else $error("ready before the write time");
    a_busy_max: assert property (busy_cnt <= BUSY_MAX)
        else $error("busy never ends");
    a_miso_fall: assert property ($changed(miso_o) |-> !sck_i && !$past(sck_i, 3))
        else $error("serial output changed away from a clock fall");
endmodule
bind mpi_top mpi_asserts #(
    .FLASH_WAIT  (FLASH_WAIT),
    .EEPROM_WAIT (EEPROM_WAIT),
    .ERASE_WAIT  (ERASE_WAIT),
    .FUSE_WAIT   (FUSE_WAIT)
) chk_u (
    .clk_sys_i         (clk_sys_i),
    .rst_i             (rst_i),
    .par_mode_i        (par_mode_i),
    .write_strobe_n_i  (write_strobe_n_i),
    .output_enable_n_i (output_enable_n_i),
    .sck_i             (sck_i),
    .data_oe_o         (data_oe_o),
    .ready_busy_o      (ready_busy_o),
    .miso_o            (miso_o)
);

// >>> verification/mpi_prog_model.sv
// serial programmer model: reset pin, serial clock and data toward the device
// assumes the bench calls start, xfer and stop from one process
module mpi_prog_model #(
    parameter int START_WAIT = 64
)(
    input  wire logic clk_sys_i,
    input  wire logic miso_i,
    output logic      reset_pin_n_o,
    output logic      sck_o,
    output logic      mosi_o
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        reset_pin_n_o = 1'b1;
        sck_o = 1'b0;
        mosi_o = 1'b0;
    end
    // 10 system clocks per phase, 160 ns clock period
    task automatic half;
        repeat (10) @(negedge clk_sys_i);
    endtask
    // start wait is scaled down to keep the run short
    task automatic start;
        sck_o = 1'b0;
        reset_pin_n_o = 1'b0;
        repeat (4) @(negedge clk_sys_i);
        reset_pin_n_o = 1'b1;
        repeat (4) @(negedge clk_sys_i);
        reset_pin_n_o = 1'b0;
        repeat (START_WAIT) @(negedge clk_sys_i);
    endtask
    // all four bytes always go out, whatever comes back
    task automatic xfer(input logic [31:0] ins, output logic [7:0] b3, output logic [7:0] b4);
        logic [31:0] rx;
        for (int i = 31; i >= 0; i--) begin
            mosi_o = ins[i];
            half;
            sck_o = 1'b1;
            rx[i] = miso_i;
            half;
            sck_o = 1'b0;
        end
        b3 = rx[15:8];
        b4 = rx[7:0];
    endtask
    task automatic stop;
        reset_pin_n_o = 1'b1;
    endtask
endmodule

// >>> verification/test_memory_programming_interface.sv
// self-checking bench for mpi_top: parallel pin tasks and a serial programmer model
// assumes shortened write times; all pins change at the falling clock edge
`include "mpi_defines.vh"
module test_memory_programming_interface;
    timeunit 1ns;
    timeprecision 1ps;
    logic       clk_sys_i = 1'b0;
    logic       rst_i = 1'b1;
    logic       par_mode_i = 1'b1;
    logic       clock_input_pin_i = 1'b0;
    logic       action_select_0_i = 1'b1;
    logic       action_select_1_i = 1'b1;
    logic       byte_select_1_i = 1'b0;
    logic       write_strobe_n_i = 1'b1;
    logic       output_enable_n_i = 1'b1;
    logic [7:0] data_i = 8'h00;
    logic [7:0] b3;
    logic [7:0] b4;
    wire  [7:0] data_o;
    wire        data_oe_o, ready_busy_o, reset_pin_n, sck, mosi, miso_o;
    int         n_mismatch = 0;
    int         num_checks = 0;
    // arbitrary identification values
    localparam logic [7:0] S0 = 8'h5A, S1 = 8'hA5, S2 = 8'h3C, CAL = 8'h80;
    initial forever #4 clk_sys_i = ~clk_sys_i;
    mpi_top #(.FLASH_WAIT(20'h003E8), .EEPROM_WAIT(20'h003E8), .ERASE_WAIT(20'h00834), .FUSE_WAIT(20'h003E8),
              .SIG0(S0), .SIG1(S1), .SIG2(S2), .CAL_BYTE(CAL)) dut_u (
        .clk_sys_i(clk_sys_i), .rst_i(rst_i), .ce_i(1'b1), .par_mode_i(par_mode_i),
        .clock_input_pin_i(clock_input_pin_i), .action_select_0_i(action_select_0_i),
        .action_select_1_i(action_select_1_i), .byte_select_1_i(byte_select_1_i),
        .write_strobe_n_i(write_strobe_n_i), .output_enable_n_i(output_enable_n_i), .data_i(data_i),
        .data_o(data_o), .data_oe_o(data_oe_o), .ready_busy_o(ready_busy_o),
        .reset_pin_n_i(reset_pin_n), .sck_i(sck), .mosi_i(mosi), .miso_o(miso_o));
    mpi_prog_model mdl_u (.clk_sys_i(clk_sys_i), .miso_i(miso_o), .reset_pin_n_o(reset_pin_n),
        .sck_o(sck), .mosi_o(mosi));
    ////////////////////////////////////////////////////////////////
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        num_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic ph;
        repeat (6) @(negedge clk_sys_i);
    endtask
    task automatic load(input logic [1:0] act, input logic bs1, input logic [7:0] d);
        {action_select_1_i, action_select_0_i} = act;
        byte_select_1_i = bs1;
        data_i = d;
        ph;
        clock_input_pin_i = 1'b1;
        ph;
        clock_input_pin_i = 1'b0;
        ph;
    endtask
    task automatic strobe(input logic bs2, input logic bs1);
        int i;
        action_select_1_i = bs2;
        byte_select_1_i = bs1;
        ph;
        write_strobe_n_i = 1'b0;
        ph;
        write_strobe_n_i = 1'b1;
        for (i = 0; i < 20 && ready_busy_o !== 1'b0; i++) @(negedge clk_sys_i);
        chk("busy", 8'h00, {7'h00, ready_busy_o});
        for (i = 0; i < 3000 && ready_busy_o !== 1'b1; i++) @(negedge clk_sys_i);
        chk("ready", 8'h01, {7'h00, ready_busy_o});
        if (ready_busy_o !== 1'b1) report_and_stop;
    endtask
    task automatic rd(input string what, input logic bs2, input logic bs1, input logic [7:0] exp);
        action_select_1_i = bs2;
        byte_select_1_i = bs1;
        output_enable_n_i = 1'b0;
        ph;
        chk(what, exp, data_oe_o === 1'b1 ? data_o : 8'hXX);
        output_enable_n_i = 1'b1;
        ph;
        chk("bus release", 8'h00, {7'h00, data_oe_o});
    endtask
    task automatic sx(input logic [31:0] ins);
        mdl_u.xfer(ins, b3, b4);
    endtask
    // polling replaces the fixed write waits
    task automatic poll;
        int i;
        sx(32'hF0000000);
        chk("poll busy", 8'h01, {7'h00, b4[0]});
        for (i = 0; i < 10 && b4[0] !== 1'b0; i++) sx(32'hF0000000);
        chk("poll done", 8'h00, {7'h00, b4[0]});
        if (b4[0] !== 1'b0) report_and_stop;
    endtask
    ////////////////////////////////////////////////////////////////
    initial begin
        repeat (90000) @(posedge clk_sys_i);
        n_mismatch++;
        report_and_stop;
    end
    initial begin
        repeat (16) @(negedge clk_sys_i);
        rst_i = 1'b0;
        ph;
        chk("ready after reset", 8'h01, {7'h00, ready_busy_o});
        load(`MPI_ACT_CMD, 1'b0, `MPI_CMD_ERASE);
        strobe(1'b0, 1'b0);
        load(`MPI_ACT_CMD, 1'b0, `MPI_CMD_WEEP);
        load(`MPI_ACT_ADDR, 1'b1, 8'h00);
        for (int k = 0; k < 3; k++) begin
            load(`MPI_ACT_ADDR, 1'b0, 8'h04 + 8'(k));
            load(`MPI_ACT_DATA, 1'b0, 8'hA0 + 8'(k));
            load(2'h3, 1'b0, 8'h00);
        end
        strobe(1'b0, 1'b0);
        load(`MPI_ACT_CMD, 1'b0, `MPI_CMD_REEP);
        load(`MPI_ACT_ADDR, 1'b1, 8'h00);
        for (int k = 0; k < 4; k++) begin
            load(`MPI_ACT_ADDR, 1'b0, 8'h04 + 8'(k));
            rd("eeprom", 1'b0, 1'b0, k < 3 ? 8'hA0 + 8'(k) : 8'hFF);
        end
        load(`MPI_ACT_CMD, 1'b0, `MPI_CMD_WFUSE);
        load(`MPI_ACT_DATA, 1'b0, 8'hE1);
        strobe(1'b0, 1'b0);
        load(`MPI_ACT_DATA, 1'b0, 8'hD2);
        strobe(1'b0, 1'b1);
        load(`MPI_ACT_DATA, 1'b0, 8'hF3);
        strobe(1'b1, 1'b0);
        load(`MPI_ACT_CMD, 1'b0, `MPI_CMD_RFUSE);
        rd("fuse low", 1'b0, 1'b0, 8'hE1);
        rd("fuse high", 1'b1, 1'b1, 8'hD2);
        rd("fuse ext", 1'b1, 1'b0, 8'hF3);
        rd("lock", 1'b0, 1'b1, 8'hFF);
        load(`MPI_ACT_CMD, 1'b0, `MPI_CMD_RSIG);
        load(`MPI_ACT_ADDR, 1'b1, 8'h00);
        for (int k = 0; k < 3; k++) begin
            load(`MPI_ACT_ADDR, 1'b0, 8'(k));
            rd("signature", 1'b0, 1'b0, k == 0 ? S0 : (k == 1 ? S1 : S2));
        end
        load(`MPI_ACT_ADDR, 1'b0, 8'h00);
        rd("calibration", 1'b0, 1'b1, CAL);
        par_mode_i = 1'b0;
        mdl_u.start;
        sx(32'hC0000855);
        sx(32'hAC530000);
        chk("enable echo", 8'h53, b3);
        sx(32'hA0000800);
        chk("eeprom untouched", 8'hFF, b4);
        sx(32'hC0000855);
        poll;
        sx(32'hA0000800);
        chk("eeprom byte", 8'h55, b4);
        sx(32'h40000334);
        sx(32'h48000312);
        sx(32'h4C000000);
        poll;
        sx(32'h20000300);
        chk("flash low", 8'h34, b4);
        sx(32'h28000300);
        chk("flash high", 8'h12, b4);
        sx(32'hC1000D77);
        sx(32'hC2000C00);
        poll;
        sx(32'hA0000C00);
        chk("eeprom unloaded", 8'hFF, b4);
        sx(32'hA0000D00);
        chk("eeprom loaded", 8'h77, b4);
        mdl_u.stop;
        par_mode_i = 1'b1;
        ph;
        load(`MPI_ACT_CMD, 1'b0, `MPI_CMD_RFLASH);
        load(`MPI_ACT_ADDR, 1'b1, 8'h00);
        load(`MPI_ACT_ADDR, 1'b0, 8'h03);
        rd("flash low", 1'b0, 1'b0, 8'h34);
        rd("flash high", 1'b0, 1'b1, 8'h12);
        load(`MPI_ACT_CMD, 1'b0, `MPI_CMD_WLOCK);
        load(`MPI_ACT_DATA, 1'b0, 8'hFC);
        strobe(1'b0, 1'b0);
        load(`MPI_ACT_DATA, 1'b0, 8'hC3);
        strobe(1'b0, 1'b0);
        load(`MPI_ACT_DATA, 1'b0, 8'hFF);
        strobe(1'b0, 1'b0);
        load(`MPI_ACT_CMD, 1'b0, `MPI_CMD_RFUSE);
        rd("lock kept", 1'b0, 1'b1, 8'hFC);
        load(`MPI_ACT_CMD, 1'b0, `MPI_CMD_ERASE);
        strobe(1'b0, 1'b0);
        load(`MPI_ACT_CMD, 1'b0, `MPI_CMD_RFUSE);
        rd("lock erased", 1'b0, 1'b1, 8'hFF);
        report_and_stop;
    end
endmodule
